/* File: testbench/swrsc_dev_model.sv */
// Behavioural token on the open-drain line: presence, identity commands.
// Assumes the shortened bench timing: slot low 6 or 12.5 us, reset 20 us.
`timescale 1ns/10ps
module swrsc_dev_model #(
   parameter logic [55:0] P_ID_LO = 56'h00_0A53_C960_E2D1 // Arbitrary.
) (
   input  wire logic       i_line,
   input  wire logic [7:0] i_mem_byte,
   output logic            o_pull_low
);
   typedef enum logic [2:0] {D_CMD, D_MATCH, D_SRCH, D_MEM, D_OFF} swrsc_dst_t;
   logic [63:0] id;
   logic [7:0]  shreg;
   logic        txb, rxb, tx;
   int          nbit, phase;
   realtime     t0, dur;
   swrsc_dst_t  st;

   initial begin
      id = {8'h00, P_ID_LO};
      for (int i = 0; i < 56; i++)
         id[63:56] = (id[56] ^ id[i]) ? ((id[63:56] >> 1) ^ 8'h8C)
                                      : (id[63:56] >> 1);
      o_pull_low = 1'b0;
      st = D_OFF;
   end

   task automatic step();
      case (st)
         D_CMD: begin
            shreg = {rxb, shreg[7:1]};
            nbit++;
            if (nbit == 8) begin
               nbit = 0;
               case (shreg)
                  8'h55: st = D_MATCH;
                  8'hCC: st = D_MEM;
                  8'hF0: st = D_SRCH;
                  default: st = D_OFF;
               endcase
            end
         end
         D_MATCH: begin
            if (rxb != id[nbit[5:0]]) st = D_OFF;
            nbit++;
            if (st == D_MATCH && nbit == 64) st = D_MEM;
         end
         D_SRCH: begin
            phase++;
            if (phase == 3) begin
               phase = 0;
               if (rxb != id[nbit[5:0]]) st = D_OFF;
               nbit++;
               if (st == D_SRCH && nbit == 64) st = D_MEM;
            end
         end
         D_MEM: nbit++;
         default: st = D_OFF;
      endcase
   endtask

   // The slot timer starts on the master's falling edge only; edges that
   // this model makes itself are ignored.
   always @(negedge i_line) begin
      if (!o_pull_low) begin
         t0 = $realtime;
         tx = (st == D_MEM) || (st == D_SRCH && phase < 2);
         txb = (st == D_MEM) ? i_mem_byte[nbit[2:0]]
                             : id[nbit[5:0]] ^ (phase == 1);
         if (tx && !txb) begin
            o_pull_low = 1'b1;
            #12500 o_pull_low = 1'b0;
         end
         wait (i_line === 1'b1);
         dur = $realtime - t0;
         if (dur > 15000.0) begin
            #300 o_pull_low = 1'b1;
            #1500 o_pull_low = 1'b0;
            st = D_CMD;
            nbit = 0;
            phase = 0;
         end else begin
            rxb = (dur <= 9000.0);
            if (st != D_OFF) step();
         end
      end
   end
endmodule // swrsc_dev_model

/* File: testbench/test_single_wire_rom_select_crc.sv */
// Self-checking bench for the bus master against the token model.
// Assumes shortened reset, slot and program counts set at the instance.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD %0t value mismatch", $time); end end
module test_single_wire_rom_select_crc;
   localparam int unsigned RLOW = 2000;
   localparam int unsigned PROG = 200;
   localparam logic [55:0] ID_LO = 56'h00_0A53_C960_E2D1; // Arbitrary.
   typedef struct {
      swrsc_pkg::swrsc_cmd_t c;
      logic [11:0]           e;
      logic [11:0]           m;
   } swrsc_note_t;
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_cmd_valid = 1'b0;
   logic i_crc_clear = 1'b0, i_crc_load = 1'b0;
   logic [15:0] i_crc_load_val = 16'h0000, o_crc16, val;
   logic [7:0]  i_cmd_data = 8'h00, o_rd_data, mem;
   logic [1:0]  o_trip_bits;
   logic o_done, o_err, o_presence, o_line_out, o_line_oe, o_vpp_en, pull;
   swrsc_pkg::swrsc_cmd_t i_cmd = swrsc_pkg::CMD_RESET;
   swrsc_note_t q[$];
   swrsc_note_t nt;
   int mismatches = 0, compares = 0, lo_cnt = 0, last_low = 0, vcnt = 0;
   wire line = ~((o_line_oe & ~o_line_out) | pull);

   swrsc_master #(.P_RST_LOW(RLOW), .P_RST_HIGH(400), .P_PRES_SAMP(100),
      .P_SLOT(1300), .P_W0_LOW(1250), .P_PROG(PROG)) dut (
      .i_sys_clk, .i_arst_n, .i_cmd_valid, .i_cmd, .i_cmd_data, .i_crc_clear,
      .i_crc_load, .i_crc_load_val, .i_line_in(line), .o_cmd_ready(),
      .o_done, .o_err, .o_rd_data, .o_presence, .o_trip_bits, .o_line_out,
      .o_line_oe, .o_vpp_en, .o_crc8(), .o_crc16, .o_crc8_zero(),
      .o_crc16_good());
   swrsc_dev_model #(.P_ID_LO(ID_LO)) model (
      .i_line(line), .i_mem_byte(mem), .o_pull_low(pull));

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic do_cmd(input swrsc_pkg::swrsc_cmd_t c, input logic [7:0] d,
                         input logic [11:0] e, input logic [11:0] m);
      int n;
      n = 0;
      q.push_back('{c, e, m});
      i_cmd = c;
      i_cmd_data = d;
      i_cmd_valid = 1'b1;
      @(posedge i_sys_clk);
      #1 i_cmd_valid = 1'b0;
      while (o_done !== 1'b1 && n < 30000) begin
         @(posedge i_sys_clk);
         #1 n++;
      end
      if (n == 30000) begin
         mismatches++;
         close_out();
      end
   endtask

   task automatic crc_op(input logic clr, input logic [15:0] v);
      i_crc_clear = clr;
      i_crc_load = !clr;
      i_crc_load_val = v;
      @(posedge i_sys_clk);
      #1 i_crc_clear = 1'b0;
      i_crc_load = 1'b0;
      `CHK(o_crc16, clr ? 16'h0000 : v)
   endtask

   // Results are judged when the master reports the end of a command.
   always @(negedge i_sys_clk) begin
      if (o_line_oe === 1'b1) lo_cnt++;
      else if (lo_cnt != 0) begin
         last_low = lo_cnt;
         lo_cnt = 0;
      end
      if (o_vpp_en === 1'b1) vcnt++;
      if (o_done === 1'b1 && q.size() > 0) begin
         nt = q.pop_front();
         `CHK({o_err, o_presence, o_trip_bits, o_rd_data} & nt.m, nt.e & nt.m)
         `CHK(o_line_out, 1'b0)
         if (nt.c == swrsc_pkg::CMD_RESET) begin
            `CHK(last_low, RLOW)
            `CHK(last_low < swrsc_pkg::RESET_MAX_CYC, 1'b1)
         end
         if (nt.c == swrsc_pkg::CMD_PROGRAM && !nt.e[11]) `CHK(vcnt, PROG)
      end
   end

   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // The tests need about 95k cycles; half as much again is a hang.
   initial begin
      #1500000;
      mismatches++;
      close_out();
   end

   initial begin
      void'($urandom(32'hACE4));
      mem = 8'($urandom);
      val = 16'($urandom) & 16'hFFFE;
      repeat (2) @(posedge i_sys_clk);
      #1 i_arst_n = 1'b1;
      do_cmd(swrsc_pkg::CMD_RESET, 8'h00, 12'h400, 12'hC00);
      do_cmd(swrsc_pkg::CMD_WRITE_BYTE, 8'hCC, 12'h4CC, 12'hCFF);
      do_cmd(swrsc_pkg::CMD_READ_BYTE, 8'hFF, {4'h4, mem}, 12'hCFF);
      $display("skip and read test done");
      do_cmd(swrsc_pkg::CMD_RESET, 8'h00, 12'h400, 12'hC00);
      do_cmd(swrsc_pkg::CMD_WRITE_BYTE, 8'hF0, 12'h4F0, 12'hCFF);
      do_cmd(swrsc_pkg::CMD_TRIPLET, 8'($urandom),
             {2'b01, ~ID_LO[0], ID_LO[0], 8'h00}, 12'hF00);
      $display("search test done");
      do_cmd(swrsc_pkg::CMD_RESET, 8'h00, 12'h400, 12'hC00);
      do_cmd(swrsc_pkg::CMD_WRITE_BYTE, 8'hA5, 12'h4A5, 12'hCFF);
      do_cmd(swrsc_pkg::CMD_TRIPLET, 8'h01, 12'hF00, 12'hF00);
      $display("unknown command test done");
      crc_op(1'b1, 16'h0000);
      crc_op(1'b0, val);
      do_cmd(swrsc_pkg::CMD_PROGRAM, 8'h00, 12'h800, 12'h800);
      crc_op(1'b0, 16'hB001);
      do_cmd(swrsc_pkg::CMD_PROGRAM, 8'h00, 12'h000, 12'h800);
      $display("program test done");
      close_out();
   end
endmodule // test_single_wire_rom_select_crc

/* File: verilog/swrsc_crc.sv */
// Bitwise CRC-8 and CRC-16 generators fed with every byte slot bit and the written bit of each search triplet.
// Assumes the caller presents at most one bit per clock.
`timescale 1ns/10ps
module swrsc_crc (
   input  wire logic        i_sys_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_clear,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_val,
   input  wire logic        i_bit_valid,
   input  wire logic        i_bit,
   output logic      [7:0]  o_crc8,
   output logic      [15:0] o_crc16,
   output logic             o_crc8_zero,
   output logic             o_crc16_good
);
   logic [7:0]  crc8_reg;
   logic [7:0]  crc8_next;
   logic [15:0] crc16_reg;
   logic [15:0] crc16_next;

   always_comb begin
      crc8_next  = crc8_reg;
      crc16_next = crc16_reg;
      if (i_clear) begin
         crc8_next  = '0;
         crc16_next = '0;
      end else if (i_load) begin
         // The address is preloaded, not shifted, for auto-advanced bytes.
         crc16_next = i_load_val;
      end else if (i_bit_valid) begin
         crc8_next  = swrsc_pkg::crc8_step(crc8_reg, i_bit);
         crc16_next = swrsc_pkg::crc16_step(crc16_reg, i_bit);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         crc8_reg  <= '0;
         crc16_reg <= '0;
      end else begin
         crc8_reg  <= crc8_next;
         crc16_reg <= crc16_next;
      end
   end

   assign o_crc8  = crc8_reg;
   assign o_crc16 = crc16_reg;
   // A received true CRC-8 leaves zero; an inverted CRC-16 leaves a residue.
   assign o_crc8_zero  = (crc8_reg == '0);
   assign o_crc16_good = (crc16_reg == swrsc_pkg::CRC16_RESIDU);
endmodule // swrsc_crc

/* File: verilog/swrsc_master.sv */
// Bus master for a single-wire EPROM token: reset, bit slots, search
// triplets and the programming pulse, with host-side CRC checking.
// Assumes an external pull-up and a 12 V switch driven by o_vpp_en.
//
// Summary of operation
// - Search: read bit, complement, write choice.
// - Reset pulse holds line low 480 us.
// - Every slot starts with master falling edge.
// - Program pulse 480 us after good CRC.
// - Reset low stays below 960 us.
// - Check byte CRC before program pulse.
// - Five signal forms, master starts all but the presence pulse.
// - Line left high when idle.
`timescale 1ns/10ps
module swrsc_master #(
   parameter int unsigned P_RST_LOW   = swrsc_pkg::RESET_LOW_CYC,
   parameter int unsigned P_RST_HIGH  = swrsc_pkg::RESET_HIGH_CYC,
   parameter int unsigned P_PRES_SAMP = swrsc_pkg::PRES_SAMP_CYC,
   parameter int unsigned P_SLOT      = swrsc_pkg::SLOT_CYC,
   parameter int unsigned P_W0_LOW    = swrsc_pkg::WRITE0_CYC,
   parameter int unsigned P_PROG      = swrsc_pkg::PROG_CYC
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_arst_n,
   input  wire logic                 i_cmd_valid,
   input  wire swrsc_pkg::swrsc_cmd_t i_cmd,
   input  wire logic [7:0]           i_cmd_data,
   input  wire logic                 i_crc_clear,
   input  wire logic                 i_crc_load,
   input  wire logic [15:0]          i_crc_load_val,
   input  wire logic                 i_line_in,
   output logic                      o_cmd_ready,
   output logic                      o_done,
   output logic                      o_err,
   output logic [7:0]                o_rd_data,
   output logic                      o_presence,
   output logic [1:0]                o_trip_bits,
   output logic                      o_line_out,
   output logic                      o_line_oe,
   output logic                      o_vpp_en,
   output logic [7:0]                o_crc8,
   output logic [15:0]               o_crc16,
   output logic                      o_crc8_zero,
   output logic                      o_crc16_good
);
   localparam int unsigned TW = swrsc_pkg::TIMER_W;
   localparam logic [TW-1:0] T_RST_LOW  = TW'(P_RST_LOW - 1);
   localparam logic [TW-1:0] T_RST_HIGH = TW'(P_RST_HIGH - 1);
   localparam logic [TW-1:0] T_PRES     = TW'(P_PRES_SAMP);
   localparam logic [TW-1:0] T_W0_LOW   = TW'(P_W0_LOW);
   localparam logic [TW-1:0] T_SH_LOW   = TW'(swrsc_pkg::SHORT_LOW_CYC);
   localparam logic [TW-1:0] T_SAMPLE   = TW'(swrsc_pkg::READ_SAMP_CYC);
   localparam logic [TW-1:0] T_SLOT_END =
      TW'(P_SLOT + swrsc_pkg::RECOVERY_CYC - 1);
   localparam logic [TW-1:0] T_PROG_DLY = TW'(swrsc_pkg::PROG_DLY_CYC - 1);
   localparam logic [TW-1:0] T_PROG     = TW'(P_PROG - 1);
   localparam logic [TW-1:0] T_LINE_MAX = TW'(swrsc_pkg::LINE_MAX_CYC);
   localparam logic [TW-1:0] T_RST_MAX  = TW'(swrsc_pkg::RESET_MAX_CYC);
   localparam logic [3:0]    BYTE_BITS  = 4'h8;
   localparam logic [3:0]    TRIP_SLOTS = 4'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT, ST_PROG_DLY, ST_PROG
   } swrsc_state_t;

   swrsc_state_t         state_reg, state_next;
   swrsc_pkg::swrsc_cmd_t cmd_reg, cmd_next;
   logic [TW-1:0] t_reg, t_next;
   logic [7:0]    shift_reg, shift_next;
   logic [3:0]    cnt_reg, cnt_next;
   logic          dir_reg, dir_next;
   logic          samp_reg, samp_next;
   logic          oe_reg, oe_next;
   logic          vpp_reg, vpp_next;
   logic          done_reg, done_next;
   logic          err_reg, err_next;
   logic          pres_reg, pres_next;
   logic [1:0]    trip_reg, trip_next;
   logic [7:0]    rd_reg, rd_next;
   logic          bitv_reg, bitv_next;
   logic          bit_reg, bit_next;
   logic          line_s1_reg, line_s2_reg, line_s3_reg, line_reg;
   logic          slot_bit;

   // Three-stage synchroniser; a change counts once stages two and three agree.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         line_s1_reg <= 1'b1;
         line_s2_reg <= 1'b1;
         line_s3_reg <= 1'b1;
         line_reg    <= 1'b1;
      end else begin
         line_s1_reg <= i_line_in;
         line_s2_reg <= line_s1_reg;
         line_s3_reg <= line_s2_reg;
         if (line_s2_reg == line_s3_reg) begin
            line_reg <= line_s3_reg;
         end
      end
   end

   // Bit put on the line in this slot; a read slot writes a one.
   always_comb begin
      if (cmd_reg == swrsc_pkg::CMD_TRIPLET) begin
         slot_bit = (cnt_reg == 4'h2) ? dir_reg : 1'b1;
      end else if (cmd_reg == swrsc_pkg::CMD_WRITE_BYTE) begin
         slot_bit = shift_reg[0];
      end else begin
         slot_bit = 1'b1;
      end
   end

   always_comb begin
      state_next = state_reg;
      cmd_next   = cmd_reg;
      t_next     = t_reg + 1'b1;
      shift_next = shift_reg;
      cnt_next   = cnt_reg;
      dir_next   = dir_reg;
      samp_next  = samp_reg;
      oe_next    = oe_reg;
      vpp_next   = vpp_reg;
      done_next  = 1'b0;
      err_next   = err_reg;
      pres_next  = pres_reg;
      trip_next  = trip_reg;
      rd_next    = rd_reg;
      bitv_next  = 1'b0;
      bit_next   = bit_reg;
      unique case (state_reg)
         ST_IDLE: begin
            t_next  = '0;
            oe_next = 1'b0;
            if (i_cmd_valid) begin
               cmd_next = i_cmd;
               err_next = 1'b0;
               cnt_next = '0;
               unique case (i_cmd)
                  swrsc_pkg::CMD_RESET: begin
                     state_next = ST_RST_LOW;
                     oe_next    = 1'b1;
                  end
                  swrsc_pkg::CMD_PROGRAM: begin
                     if (o_crc16_good) begin
                        state_next = ST_PROG_DLY;
                     end else begin
                        err_next  = 1'b1;
                        done_next = 1'b1;
                     end
                  end
                  default: begin
                     state_next = ST_SLOT;
                     oe_next    = 1'b1;
                     shift_next = (i_cmd == swrsc_pkg::CMD_WRITE_BYTE) ?
                                  i_cmd_data : 8'hFF;
                     dir_next   = i_cmd_data[0];
                  end
               endcase
            end
         end
         ST_RST_LOW: begin
            if (t_reg == T_RST_LOW) begin
               state_next = ST_RST_HIGH;
               oe_next    = 1'b0;
               t_next     = '0;
            end
         end
         ST_RST_HIGH: begin
            if (t_reg == T_PRES) begin
               pres_next = ~line_reg;
            end
            if (t_reg == T_RST_HIGH) begin
               state_next = ST_IDLE;
               done_next  = 1'b1;
            end
         end
         ST_SLOT: begin
            oe_next = t_next < (slot_bit ? T_SH_LOW : T_W0_LOW);
            if (t_reg == T_SAMPLE) begin
               samp_next = line_reg;
            end
            if (t_reg == T_SLOT_END) begin
               t_next   = '0;
               cnt_next = cnt_reg + 1'b1;
               if (cmd_reg == swrsc_pkg::CMD_TRIPLET) begin
                  if (cnt_reg == 4'h0) begin
                     trip_next[0] = samp_reg;
                  end else if (cnt_reg == 4'h1) begin
                     trip_next[1] = samp_reg;
                     if (trip_reg[0] != samp_reg) begin
                        dir_next = trip_reg[0];
                     end else if (samp_reg) begin
                        err_next = 1'b1;
                        dir_next = 1'b1;
                     end
                  end else begin
                     bitv_next = 1'b1;
                     bit_next  = dir_reg;
                  end
               end else begin
                  bitv_next  = 1'b1;
                  bit_next   = samp_reg;
                  shift_next = {samp_reg, shift_reg[7:1]};
               end
               if (cnt_next == ((cmd_reg == swrsc_pkg::CMD_TRIPLET) ?
                                TRIP_SLOTS : BYTE_BITS)) begin
                  state_next = ST_IDLE;
                  oe_next    = 1'b0;
                  done_next  = 1'b1;
                  rd_next    = {samp_reg, shift_reg[7:1]};
               end else begin
                  oe_next = 1'b1;
               end
            end
         end
         ST_PROG_DLY: begin
            if (t_reg == T_PROG_DLY) begin
               state_next = ST_PROG;
               vpp_next   = 1'b1;
               t_next     = '0;
            end
         end
         ST_PROG: begin
            if (t_reg == T_PROG) begin
               state_next = ST_IDLE;
               vpp_next   = 1'b0;
               done_next  = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ST_IDLE;
         cmd_reg   <= swrsc_pkg::CMD_RESET;
         t_reg     <= '0;
         shift_reg <= '0;
         cnt_reg   <= '0;
         dir_reg   <= 1'b0;
         samp_reg  <= 1'b1;
         oe_reg    <= 1'b0;
         vpp_reg   <= 1'b0;
         done_reg  <= 1'b0;
         err_reg   <= 1'b0;
         pres_reg  <= 1'b0;
         trip_reg  <= '0;
         rd_reg    <= '0;
         bitv_reg  <= 1'b0;
         bit_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg   <= cmd_next;
         t_reg     <= t_next;
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         dir_reg   <= dir_next;
         samp_reg  <= samp_next;
         oe_reg    <= oe_next;
         vpp_reg   <= vpp_next;
         done_reg  <= done_next;
         err_reg   <= err_next;
         pres_reg  <= pres_next;
         trip_reg  <= trip_next;
         rd_reg    <= rd_next;
         bitv_reg  <= bitv_next;
         bit_reg   <= bit_next;
      end
   end

   swrsc_crc u_crc (
      .i_sys_clk    (i_sys_clk),
      .i_arst_n     (i_arst_n),
      .i_clear      (i_crc_clear),
      .i_load       (i_crc_load),
      .i_load_val   (i_crc_load_val),
      .i_bit_valid  (bitv_reg),
      .i_bit        (bit_reg),
      .o_crc8       (o_crc8),
      .o_crc16      (o_crc16),
      .o_crc8_zero  (o_crc8_zero),
      .o_crc16_good (o_crc16_good)
   );

   assign o_cmd_ready = (state_reg == ST_IDLE);
   assign o_done      = done_reg;
   assign o_err       = err_reg;
   assign o_rd_data   = rd_reg;
   assign o_presence  = pres_reg;
   assign o_trip_bits = trip_reg;
   assign o_line_out  = 1'b0;
   assign o_line_oe   = oe_reg;
   assign o_vpp_en    = vpp_reg;

   // Run lengths of the pull-down and of the 12 V pulse, for checking only.
   logic [TW-1:0] low_run_reg;
   logic [TW-1:0] vpp_run_reg;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         low_run_reg <= '0;
         vpp_run_reg <= '0;
      end else begin
         low_run_reg <= oe_reg ? low_run_reg + 1'b1 : '0;
         vpp_run_reg <= vpp_reg ? vpp_run_reg + 1'b1 : '0;
      end
   end

   a_reset_low_min: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      $fell(oe_reg) && state_reg == ST_RST_HIGH |-> low_run_reg == T_RST_LOW + 1'b1)
      else $error("reset pulse length wrong");
   a_reset_low_max: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      oe_reg |-> low_run_reg < T_RST_MAX)
      else $error("line held low too long");
   a_slot_low_max: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      oe_reg && state_reg == ST_SLOT |-> low_run_reg < T_LINE_MAX)
      else $error("slot low exceeds reset threshold");
   a_idle_released: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> !oe_reg)
      else $error("line not released while idle");
   a_slot_start_low: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state_reg == ST_SLOT && t_reg == '0 |-> oe_reg)
      else $error("slot began without falling edge");
   a_slot_low_form: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      $fell(oe_reg) && state_reg == ST_SLOT |->
      low_run_reg == T_SH_LOW || low_run_reg == T_W0_LOW)
      else $error("slot low time not a legal form");
   a_vpp_width: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      $fell(vpp_reg) |-> vpp_run_reg == T_PROG + 1'b1 && state_reg == ST_IDLE)
      else $error("program pulse width wrong");
   a_vpp_no_pull: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      vpp_reg |-> !oe_reg && state_reg == ST_PROG)
      else $error("pull-down during program pulse");
   a_prog_crc_ok: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state_reg == ST_PROG_DLY && $past(state_reg) == ST_IDLE |-> $past(o_crc16_good))
      else $error("program pulse without good CRC");
   a_trip_direction: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      done_reg && cmd_reg == swrsc_pkg::CMD_TRIPLET && trip_reg[0] != trip_reg[1]
      |-> dir_reg == trip_reg[0])
      else $error("search wrote wrong direction");
   a_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      done_reg |-> state_reg == ST_IDLE ##1 !done_reg)
      else $error("done longer than one cycle");
endmodule // swrsc_master

/* File: verilog/swrsc_pkg.sv */
// Constants, command codes and CRC step functions for the single-wire
// bus master. Assumes a 100 MHz system clock; all times are given in
// microseconds and converted to clock cycles here.
package swrsc_pkg;
   localparam int unsigned CLK_NS = 10;

   // Least times round up, longest times round down.
   localparam int unsigned RESET_LOW_TIME_US     = 480;
   localparam int unsigned RESET_LOW_MAX_US      = 960;
   localparam int unsigned RESET_HIGH_US         = 480;
   localparam int unsigned PRESENCE_SAMPLE_US    = 70;
   localparam int unsigned SLOT_US               = 70;
   localparam int unsigned WRITE0_LOW_US         = 60;
   localparam int unsigned SHORT_LOW_US          = 6;
   localparam int unsigned READ_SAMPLE_US        = 12;
   localparam int unsigned RECOVERY_US           = 10;
   localparam int unsigned LINE_LOW_MAX_US       = 120;
   localparam int unsigned PROG_DELAY_US         = 5;
   localparam int unsigned PROG_PULSE_US         = 480;

   localparam int unsigned RESET_LOW_CYC  = (RESET_LOW_TIME_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned RESET_MAX_CYC  = (RESET_LOW_MAX_US*1000) / CLK_NS;
   localparam int unsigned RESET_HIGH_CYC = (RESET_HIGH_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned PRES_SAMP_CYC  = (PRESENCE_SAMPLE_US*1000) / CLK_NS;
   localparam int unsigned SLOT_CYC       = (SLOT_US*1000+CLK_NS-1) / CLK_NS;
   localparam int unsigned WRITE0_CYC     = (WRITE0_LOW_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned SHORT_LOW_CYC  = (SHORT_LOW_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned READ_SAMP_CYC  = (READ_SAMPLE_US*1000) / CLK_NS;
   localparam int unsigned RECOVERY_CYC   = (RECOVERY_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned LINE_MAX_CYC   = (LINE_LOW_MAX_US*1000) / CLK_NS;
   localparam int unsigned PROG_DLY_CYC   = (PROG_DELAY_US*1000+CLK_NS-1)
                                            / CLK_NS;
   localparam int unsigned PROG_CYC       = (PROG_PULSE_US*1000+CLK_NS-1)
                                            / CLK_NS;

   localparam int unsigned TIMER_W = 17;

   // Identity command bytes, sent with a write-byte command.
   localparam logic [7:0] ID_SELECT = 8'h55;
   localparam logic [7:0] ID_SKIP   = 8'hCC;
   localparam logic [7:0] ID_SEARCH = 8'hF0;

   localparam logic [7:0]  CRC8_POLY    = 8'h8C;
   localparam logic [15:0] CRC16_POLY   = 16'hA001;
   localparam logic [15:0] CRC16_RESIDU = 16'hB001;

   typedef enum logic [2:0] {
      CMD_RESET,
      CMD_WRITE_BYTE,
      CMD_READ_BYTE,
      CMD_TRIPLET,
      CMD_PROGRAM
   } swrsc_cmd_t;

   // Bits travel least significant first, so both generators are reflected.
   function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                            input logic b);
      crc8_step = (c[0] ^ b) ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
   endfunction

   function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                              input logic b);
      crc16_step = (c[0] ^ b) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
   endfunction
endpackage
